//--- verilog/cad_pkg.sv
// Constants, codes and types for the command/address bus decoder
//----------------------------------------------------------------------
// What this block does
// - Each non-deselect command spans two cycles; sample select and six lines.
// - Deselect is one cycle with select low; does nothing unless a second half was due, then flags proto_err.
// - Three bank bits in the second cycle pick the target bank.
// - All-banks flag high applies refresh or precharge to every bank.
// - Auto-precharge flag closes the bank after the access.
// - With on-the-fly burst enabled, flag high means 32, low means 16.
// - Column second half omits column bits 1..0; treat them as zero.
// - Activate halves carry row and bank bits in the fixed line layout.
// - Read, write and masked write codes carry burst, bank, column 9, precharge.
// - Mode register read carries the six register index bits next cycle.
// - Mode write halves and multi-purpose carry operand bits in fixed layout.
// - Decode refresh, self refresh entry/exit and precharge codes with flags.
// - Reserved first-cycle codes are recognised and reported as reserved.
//----------------------------------------------------------------------
package cad_pkg;

   localparam int CA_W   = 6;
   localparam int BANK_W = 3;
   localparam int NBANK  = 8;
   localparam int ROW_W  = 16;
   localparam int COL_W  = 10;
   localparam int IDX_W  = 6;
   localparam int OP_W   = 8;

   // First-cycle codes on lines 4..0, activate codes on lines 1..0 only (line 0 in bit 0)
   localparam logic [1:0] ACT1_CODE = 2'h1;
   localparam logic [1:0] ACT2_CODE = 2'h3;
   localparam logic [4:0] MPC_CODE  = 5'h00;
   localparam logic [4:0] PRE_CODE  = 5'h10;
   localparam logic [4:0] REF_CODE  = 5'h08;
   localparam logic [4:0] SRE_CODE  = 5'h18;
   localparam logic [4:0] WR_CODE   = 5'h04;
   localparam logic [4:0] SRX_CODE  = 5'h14;
   localparam logic [4:0] MWR_CODE  = 5'h0C;
   localparam logic [4:0] RD_CODE   = 5'h02;
   localparam logic [4:0] CAS2_CODE = 5'h12;
   localparam logic [4:0] MRW1_CODE = 5'h06;
   localparam logic [4:0] MRW2_CODE = 5'h16;
   localparam logic [4:0] MRR1_CODE = 5'h0E;

   // Multi-purpose operands that need a column second half
   localparam logic [7:0] MPC_RD_FIFO  = 8'h41;
   localparam logic [7:0] MPC_WR_FIFO  = 8'h47;
   localparam logic [7:0] MPC_RD_DQCAL = 8'h43;

   // Values after reset, and the all-banks mask
   localparam logic [ROW_W-1:0]  ROW_RST  = 16'h0000;
   localparam logic [COL_W-1:0]  COL_RST  = 10'h000;
   localparam logic [BANK_W-1:0] BANK_RST = 3'h0;
   localparam logic [NBANK-1:0]  MASK_RST = 8'h00;
   localparam logic [NBANK-1:0]  MASK_ALL = 8'hFF;
   localparam logic [IDX_W-1:0]  IDX_RST  = 6'h00;
   localparam logic [OP_W-1:0]   OP_RST   = 8'h00;
   localparam logic [CA_W-1:0]   CA_RST   = 6'h00;

   typedef enum logic [3:0] {
      K_MPC  = 4'h0,
      K_PRE  = 4'h1,
      K_REF  = 4'h2,
      K_SRE  = 4'h3,
      K_SRX  = 4'h4,
      K_WR   = 4'h5,
      K_MWR  = 4'h6,
      K_RD   = 4'h7,
      K_CAS2 = 4'h8,
      K_MRW1 = 4'h9,
      K_MRW2 = 4'hA,
      K_MRR1 = 4'hB,
      K_ACT1 = 4'hC,
      K_ACT2 = 4'hD,
      K_RFU  = 4'hE
   } cad_kind_t;

   typedef enum logic {
      ST_FIRST  = 1'b0,
      ST_SECOND = 1'b1
   } cad_state_t;

   typedef enum logic [1:0] {
      W_NONE = 2'h0,
      W_CAS  = 2'h1,
      W_ACT2 = 2'h2,
      W_MRW2 = 2'h3
   } cad_want_t;

endpackage

//--- verilog/cad_sync.sv
// Two-stage synchroniser for the select and command/address pins
module cad_sync #(
   parameter int WIDTH = 7
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_comb begin
            meta_d[g] = clk_en ? async_in[g] : meta_q[g];
            sync_d[g] = clk_en ? meta_q[g] : sync_q[g];
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule

//--- verilog/cad_classify.sv
// First-cycle command classifier
module cad_classify (
   input  wire logic [cad_pkg::CA_W-1:0] first_half,
   output cad_pkg::cad_kind_t            kind
);

   always_comb begin
      if (first_half[1:0] == cad_pkg::ACT1_CODE) begin
         kind = cad_pkg::K_ACT1;
      end else if (first_half[1:0] == cad_pkg::ACT2_CODE) begin
         kind = cad_pkg::K_ACT2;
      end else begin
         case (first_half[4:0])
            cad_pkg::MPC_CODE:  kind = cad_pkg::K_MPC;
            cad_pkg::PRE_CODE:  kind = cad_pkg::K_PRE;
            cad_pkg::REF_CODE:  kind = cad_pkg::K_REF;
            cad_pkg::SRE_CODE:  kind = cad_pkg::K_SRE;
            cad_pkg::SRX_CODE:  kind = cad_pkg::K_SRX;
            cad_pkg::WR_CODE:   kind = cad_pkg::K_WR;
            cad_pkg::MWR_CODE:  kind = cad_pkg::K_MWR;
            cad_pkg::RD_CODE:   kind = cad_pkg::K_RD;
            cad_pkg::CAS2_CODE: kind = cad_pkg::K_CAS2;
            cad_pkg::MRW1_CODE: kind = cad_pkg::K_MRW1;
            cad_pkg::MRW2_CODE: kind = cad_pkg::K_MRW2;
            cad_pkg::MRR1_CODE: kind = cad_pkg::K_MRR1;
            default:            kind = cad_pkg::K_RFU;
         endcase
      end
   end

endmodule

//--- verilog/cad_decoder.sv
// Command/address bus decoder: pairs halves, extracts fields, flags misuse
module cad_decoder (
   input  wire logic                       clock,
   input  wire logic                       arst_n,
   input  wire logic                       clk_en,
   input  wire logic                       cs_pin,
   input  wire logic [cad_pkg::CA_W-1:0]   cmd_addr_lines,
   input  wire logic                       otf_burst_en,
   input  wire logic                       burst32_default,
   output logic                            cmd_valid,
   output cad_pkg::cad_kind_t              cmd_kind,
   output logic [cad_pkg::BANK_W-1:0]      bank_sel,
   output logic [cad_pkg::NBANK-1:0]       bank_mask,
   output logic                            all_banks_flag,
   output logic [cad_pkg::ROW_W-1:0]       row_addr,
   output logic [cad_pkg::COL_W-1:0]       col_addr,
   output logic                            auto_precharge_flag,
   output logic                            burst_is_32,
   output logic [cad_pkg::IDX_W-1:0]       mode_reg_index,
   output logic [cad_pkg::OP_W-1:0]        operand_bits,
   output logic                            proto_err
);

   //----------------------------------------------------------------
   // Pin synchronisation and classification
   //----------------------------------------------------------------
   logic [cad_pkg::CA_W:0]   pins_s;
   logic                     cs_s;
   logic [cad_pkg::CA_W-1:0] ca_s;
   cad_pkg::cad_kind_t       kind_w;

   cad_sync #(
      .WIDTH (cad_pkg::CA_W + 1)
   ) u_sync (
      .clock    (clock),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .async_in ({cs_pin, cmd_addr_lines}),
      .sync_out (pins_s)
   );

   assign cs_s = pins_s[cad_pkg::CA_W];
   assign ca_s = pins_s[cad_pkg::CA_W-1:0];

   cad_pkg::cad_state_t      st_q, st_d;
   cad_pkg::cad_want_t       want_q, want_d;
   logic [cad_pkg::CA_W-1:0] c1_q, c1_d;

   cad_classify u_classify (
      .first_half (c1_q),
      .kind       (kind_w)
   );

   function automatic logic [cad_pkg::NBANK-1:0] bank_onehot(input logic [cad_pkg::BANK_W-1:0] b,
                                                             input logic ab);
      logic [cad_pkg::NBANK-1:0] m;
      m = '0;
      m[b] = 1'b1;
      return ab ? cad_pkg::MASK_ALL : m;
   endfunction

   //----------------------------------------------------------------
   // Held first-half fields and output registers
   //----------------------------------------------------------------
   cad_pkg::cad_kind_t          hold_kind_q, hold_kind_d;
   logic [cad_pkg::BANK_W-1:0]  hold_bank_q, hold_bank_d;
   logic [5:0]                  hold_row_q, hold_row_d;
   logic                        hold_c9_q, hold_c9_d;
   logic                        hold_ap_q, hold_ap_d;
   logic                        hold_bl_q, hold_bl_d;
   logic [cad_pkg::IDX_W-1:0]   hold_idx_q, hold_idx_d;
   logic [cad_pkg::OP_W-1:0]    hold_op_q, hold_op_d;

   logic                        vld_q, vld_d;
   cad_pkg::cad_kind_t          kind_q, kind_d;
   logic [cad_pkg::BANK_W-1:0]  bank_q, bank_d;
   logic [cad_pkg::NBANK-1:0]   mask_q, mask_d;
   logic                        ab_q, ab_d;
   logic [cad_pkg::ROW_W-1:0]   row_q, row_d;
   logic [cad_pkg::COL_W-1:0]   col_q, col_d;
   logic                        ap_q, ap_d;
   logic                        b32_q, b32_d;
   logic [cad_pkg::IDX_W-1:0]   idx_q, idx_d;
   logic [cad_pkg::OP_W-1:0]    op_q, op_d;
   logic                        err_q, err_d;

   logic                        pair_ok;
   logic [cad_pkg::OP_W-1:0]    mpc_op;

   //----------------------------------------------------------------
   // Decode state machine
   //----------------------------------------------------------------
   always_comb begin
      st_d        = st_q;
      want_d      = want_q;
      c1_d        = c1_q;
      hold_kind_d = hold_kind_q;
      hold_bank_d = hold_bank_q;
      hold_row_d  = hold_row_q;
      hold_c9_d   = hold_c9_q;
      hold_ap_d   = hold_ap_q;
      hold_bl_d   = hold_bl_q;
      hold_idx_d  = hold_idx_q;
      hold_op_d   = hold_op_q;
      vld_d       = 1'b0;
      err_d       = 1'b0;
      kind_d      = kind_q;
      bank_d      = bank_q;
      mask_d      = mask_q;
      ab_d        = ab_q;
      row_d       = row_q;
      col_d       = col_q;
      ap_d        = ap_q;
      b32_d       = b32_q;
      idx_d       = idx_q;
      op_d        = op_q;
      mpc_op      = {1'b0, c1_q[5], ca_s};
      pair_ok     = (want_q == cad_pkg::W_CAS && kind_w == cad_pkg::K_CAS2) ||
                    (want_q == cad_pkg::W_ACT2 && kind_w == cad_pkg::K_ACT2) ||
                    (want_q == cad_pkg::W_MRW2 && kind_w == cad_pkg::K_MRW2);
      case (st_q)
         cad_pkg::ST_FIRST: begin
            if (cs_s) begin
               c1_d = ca_s;
               st_d = cad_pkg::ST_SECOND;
            end else if (want_q != cad_pkg::W_NONE) begin
               // Deselect where a second half was due
               err_d  = 1'b1;
               want_d = cad_pkg::W_NONE;
            end
            // Plain deselect: nothing latched, no operation
         end
         cad_pkg::ST_SECOND: begin
            if (cs_s) begin
               // Select held high: restart as a new first cycle
               err_d  = 1'b1;
               c1_d   = ca_s;
               want_d = cad_pkg::W_NONE;
            end else begin
               st_d   = cad_pkg::ST_FIRST;
               want_d = cad_pkg::W_NONE;
               if (want_q != cad_pkg::W_NONE && !pair_ok) begin
                  err_d = 1'b1;
               end
               case (kind_w)
                  cad_pkg::K_ACT1: begin
                     hold_bank_d = ca_s[2:0];
                     hold_row_d  = {c1_q[5:2], ca_s[5:4]};
                     want_d      = cad_pkg::W_ACT2;
                  end
                  cad_pkg::K_ACT2: begin
                     if (pair_ok) begin
                        vld_d  = 1'b1;
                        kind_d = cad_pkg::K_ACT1;
                        bank_d = hold_bank_q;
                        mask_d = bank_onehot(hold_bank_q, 1'b0);
                        ab_d   = 1'b0;
                        row_d  = {hold_row_q, c1_q[5:2], ca_s};
                     end else begin
                        err_d = 1'b1;
                     end
                  end
                  cad_pkg::K_RD, cad_pkg::K_WR, cad_pkg::K_MWR: begin
                     hold_kind_d = kind_w;
                     hold_bl_d   = c1_q[5];
                     hold_bank_d = ca_s[2:0];
                     hold_c9_d   = ca_s[4];
                     hold_ap_d   = ca_s[5];
                     want_d      = cad_pkg::W_CAS;
                  end
                  cad_pkg::K_MRR1: begin
                     hold_kind_d = cad_pkg::K_MRR1;
                     hold_idx_d  = ca_s;
                     hold_ap_d   = 1'b0;
                     want_d      = cad_pkg::W_CAS;
                  end
                  cad_pkg::K_MRW1: begin
                     hold_op_d  = {c1_q[5], 7'h00};
                     hold_idx_d = ca_s;
                     want_d     = cad_pkg::W_MRW2;
                  end
                  cad_pkg::K_MRW2: begin
                     if (pair_ok) begin
                        vld_d  = 1'b1;
                        kind_d = cad_pkg::K_MRW1;
                        idx_d  = hold_idx_q;
                        op_d   = {hold_op_q[7], c1_q[5], ca_s};
                     end else begin
                        err_d = 1'b1;
                     end
                  end
                  cad_pkg::K_MPC: begin
                     if (mpc_op == cad_pkg::MPC_RD_FIFO || mpc_op == cad_pkg::MPC_WR_FIFO ||
                         mpc_op == cad_pkg::MPC_RD_DQCAL) begin
                        // Training operand waits for its column half
                        hold_kind_d = cad_pkg::K_MPC;
                        hold_op_d   = mpc_op;
                        hold_ap_d   = 1'b0;
                        want_d      = cad_pkg::W_CAS;
                     end else begin
                        vld_d  = 1'b1;
                        kind_d = cad_pkg::K_MPC;
                        op_d   = mpc_op;
                     end
                  end
                  cad_pkg::K_CAS2: begin
                     if (pair_ok) begin
                        vld_d  = 1'b1;
                        kind_d = hold_kind_q;
                        bank_d = hold_bank_q;
                        mask_d = bank_onehot(hold_bank_q, 1'b0);
                        ab_d   = 1'b0;
                        col_d  = {hold_c9_q, c1_q[5], ca_s, 2'b00};
                        ap_d   = hold_ap_q;
                        b32_d  = otf_burst_en ? hold_bl_q : burst32_default;
                        idx_d  = hold_idx_q;
                        op_d   = hold_op_q;
                     end else begin
                        err_d = 1'b1;
                     end
                  end
                  cad_pkg::K_REF, cad_pkg::K_PRE: begin
                     vld_d  = 1'b1;
                     kind_d = kind_w;
                     ab_d   = c1_q[5];
                     bank_d = ca_s[2:0];
                     mask_d = bank_onehot(ca_s[2:0], c1_q[5]);
                  end
                  cad_pkg::K_SRE, cad_pkg::K_SRX: begin
                     vld_d  = 1'b1;
                     kind_d = kind_w;
                  end
                  default: begin
                     vld_d  = 1'b1;
                     kind_d = cad_pkg::K_RFU;
                  end
               endcase
            end
         end
         default: begin
            st_d = cad_pkg::ST_FIRST;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_q        <= cad_pkg::ST_FIRST;
         want_q      <= cad_pkg::W_NONE;
         c1_q        <= cad_pkg::CA_RST;
         hold_kind_q <= cad_pkg::K_RFU;
         hold_bank_q <= cad_pkg::BANK_RST;
         hold_row_q  <= 6'h00;
         hold_c9_q   <= 1'b0;
         hold_ap_q   <= 1'b0;
         hold_bl_q   <= 1'b0;
         hold_idx_q  <= cad_pkg::IDX_RST;
         hold_op_q   <= cad_pkg::OP_RST;
         vld_q       <= 1'b0;
         kind_q      <= cad_pkg::K_RFU;
         bank_q      <= cad_pkg::BANK_RST;
         mask_q      <= cad_pkg::MASK_RST;
         ab_q        <= 1'b0;
         row_q       <= cad_pkg::ROW_RST;
         col_q       <= cad_pkg::COL_RST;
         ap_q        <= 1'b0;
         b32_q       <= 1'b0;
         idx_q       <= cad_pkg::IDX_RST;
         op_q        <= cad_pkg::OP_RST;
         err_q       <= 1'b0;
      end else if (clk_en) begin
         st_q        <= st_d;
         want_q      <= want_d;
         c1_q        <= c1_d;
         hold_kind_q <= hold_kind_d;
         hold_bank_q <= hold_bank_d;
         hold_row_q  <= hold_row_d;
         hold_c9_q   <= hold_c9_d;
         hold_ap_q   <= hold_ap_d;
         hold_bl_q   <= hold_bl_d;
         hold_idx_q  <= hold_idx_d;
         hold_op_q   <= hold_op_d;
         vld_q       <= vld_d;
         kind_q      <= kind_d;
         bank_q      <= bank_d;
         mask_q      <= mask_d;
         ab_q        <= ab_d;
         row_q       <= row_d;
         col_q       <= col_d;
         ap_q        <= ap_d;
         b32_q       <= b32_d;
         idx_q       <= idx_d;
         op_q        <= op_d;
         err_q       <= err_d;
      end
   end

   assign cmd_valid           = vld_q;
   assign cmd_kind            = kind_q;
   assign bank_sel            = bank_q;
   assign bank_mask           = mask_q;
   assign all_banks_flag      = ab_q;
   assign row_addr            = row_q;
   assign col_addr            = col_q;
   assign auto_precharge_flag = ap_q;
   assign burst_is_32         = b32_q;
   assign mode_reg_index      = idx_q;
   assign operand_bits        = op_q;
   assign proto_err           = err_q;

   //----------------------------------------------------------------
   // Checks (enabled edges only, so a frozen clock enable is harmless)
   //----------------------------------------------------------------
   default clocking cb @(posedge clock iff clk_en);
   endclocking
   default disable iff (!arst_n);

   property p_two_cycle;
      st_q == cad_pkg::ST_FIRST && cs_s |=> st_q == cad_pkg::ST_SECOND && c1_q == $past(ca_s);
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("first cycle not followed by second");

   property p_deselect_quiet;
      st_q == cad_pkg::ST_FIRST && !cs_s && want_q == cad_pkg::W_NONE |=> !vld_q && !err_q;
   endproperty
   a_deselect_quiet: assert property (p_deselect_quiet) else $error("deselect caused activity");

   property p_bank_one;
      vld_q && !ab_q && (kind_q == cad_pkg::K_REF || kind_q == cad_pkg::K_PRE) |->
         mask_q == bank_onehot(bank_q, 1'b0) && bank_q == $past(ca_s[2:0]);
   endproperty
   a_bank_one: assert property (p_bank_one) else $error("bank mask does not match bank bits");

   property p_all_banks;
      vld_q && ab_q |-> mask_q == cad_pkg::MASK_ALL && $past(c1_q[5]);
   endproperty
   a_all_banks: assert property (p_all_banks) else $error("all-banks flag without full mask");

   property p_col_low;
      vld_q && (kind_q == cad_pkg::K_RD || kind_q == cad_pkg::K_WR || kind_q == cad_pkg::K_MWR) |->
         col_q[1:0] == 2'b00 && col_q[7:2] == $past(ca_s) && ap_q == $past(hold_ap_q, 1);
   endproperty
   a_col_low: assert property (p_col_low) else $error("column or precharge field wrong");

   property p_burst;
      vld_q && kind_q == cad_pkg::K_RD |->
         b32_q == ($past(otf_burst_en) ? $past(hold_bl_q) : $past(burst32_default));
   endproperty
   a_burst: assert property (p_burst) else $error("burst length choice wrong");

   property p_act_row;
      vld_q && kind_q == cad_pkg::K_ACT1 |-> row_q[5:0] == $past(ca_s) && row_q[9:6] == $past(c1_q[5:2]);
   endproperty
   a_act_row: assert property (p_act_row) else $error("activate row bits wrong");

   property p_orphan;
      st_q == cad_pkg::ST_SECOND && !cs_s && want_q == cad_pkg::W_NONE &&
         (kind_w == cad_pkg::K_CAS2 || kind_w == cad_pkg::K_ACT2 || kind_w == cad_pkg::K_MRW2) |=>
         err_q && !vld_q;
   endproperty
   a_orphan: assert property (p_orphan) else $error("orphan second half not flagged");

   property p_missing;
      st_q == cad_pkg::ST_FIRST && !cs_s && want_q != cad_pkg::W_NONE |=> err_q ##1 !err_q || cs_s;
   endproperty
   a_missing: assert property (p_missing) else $error("missing second half not flagged");

   property p_reserved;
      st_q == cad_pkg::ST_SECOND && !cs_s && kind_w == cad_pkg::K_RFU |=> vld_q && kind_q == cad_pkg::K_RFU;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code not reported");

   property p_mrw;
      vld_q && kind_q == cad_pkg::K_MRW1 |-> op_q[5:0] == $past(ca_s) && op_q[6] == $past(c1_q[5]);
   endproperty
   a_mrw: assert property (p_mrw) else $error("mode write operand wrong");

endmodule

//--- verification/cad_ctl_model.sv
// Memory controller model driving select and command/address pins
module cad_ctl_model (
   input  wire logic                     clock,
   output logic                          cs_pin,
   output logic [cad_pkg::CA_W-1:0]      cmd_addr_lines
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_pin = 1'b0;
      cmd_addr_lines = 6'h00;
   end
   // One valid cycle, driven just after the edge
   task automatic cyc(input logic cs, input logic [cad_pkg::CA_W-1:0] ca);
      @(posedge clock);
      #5;
      cs_pin = cs;
      cmd_addr_lines = ca;
   endtask
   // Floating lines: never leave the last value showing
   task automatic des();
      @(posedge clock);
      #5;
      cs_pin = 1'b0;
      cmd_addr_lines = ~cmd_addr_lines;
   endtask
endmodule

//--- verification/tb_cad_decoder.sv
// Self-checking bench for the command/address decoder
module tb_cad_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clock = 1'b0;
   logic               arst_n = 1'b0;
   logic               otf = 1'b0;
   logic               cs, vld, ab, ap, b32, err;
   logic [5:0]         ca, idx;
   logic [2:0]         bsel;
   logic [7:0]         mask, op;
   logic [15:0]        row;
   logic [9:0]         col;
   cad_pkg::cad_kind_t kind;
   int                 num_errors = 0, checks = 0, nv = 0, ne = 0;
   cad_pkg::cad_kind_t ks[7] = '{cad_pkg::K_RD, cad_pkg::K_WR, cad_pkg::K_MWR, cad_pkg::K_SRE,
                                 cad_pkg::K_SRX, cad_pkg::K_MPC, cad_pkg::K_RFU};
   logic [4:0]         cd[7] = '{cad_pkg::RD_CODE, cad_pkg::WR_CODE, cad_pkg::MWR_CODE, cad_pkg::SRE_CODE,
                                 cad_pkg::SRX_CODE, cad_pkg::MPC_CODE, 5'h0A};
   always #25 clock = ~clock;
   always @(posedge clock) begin
      #1;
      nv += (vld === 1'b1);
      ne += (err === 1'b1);
   end
   cad_ctl_model ctl (.clock(clock), .cs_pin(cs), .cmd_addr_lines(ca));
   cad_decoder dut (.clock(clock), .arst_n(arst_n), .clk_en(1'b1), .cs_pin(cs), .cmd_addr_lines(ca),
      .otf_burst_en(otf), .burst32_default(1'b1), .cmd_valid(vld), .cmd_kind(kind), .bank_sel(bsel),
      .bank_mask(mask), .all_banks_flag(ab), .row_addr(row), .col_addr(col), .auto_precharge_flag(ap),
      .burst_is_32(b32), .mode_reg_index(idx), .operand_bits(op), .proto_err(err));
   task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic go(input logic [5:0] a, input logic [5:0] b);
      ctl.cyc(1'b1, a);
      ctl.cyc(1'b0, b);
   endtask
   // Four idle cycles cover the decode latency of three (two sync stages, one output register)
   task automatic done(input int v, input int e);
      repeat (4) ctl.des();
      chk("valid count", 16'(nv), 16'(v));
      chk("error count", 16'(ne), 16'(e));
      nv = 0;
      ne = 0;
   endtask
   initial begin
      #60us;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge clock);
      #5 arst_n = 1'b1;
      done(0, 0);
      go({4'hA, 2'h1}, {2'h1, 1'b0, 3'h5});
      go({4'h7, 2'h3}, 6'h03);
      done(1, 0);
      chk("row", row, 16'hA5C3);
      chk("mask", 16'(mask), 16'h0020);
      for (int i = 0; i < 7; i++) begin
         otf = (i != 0);
         if (i < 3) begin
            go({i == 1, cd[i]}, {i != 1, 1'b1, 1'b0, 3'h2});
            go({1'b0, cad_pkg::CAS2_CODE}, 6'h28);
         end else
            go({1'b0, cd[i]}, 6'h00);
         done(1, 0);
         chk("kind", 16'(kind), 16'(ks[i]));
         if (i < 3) begin
            chk("col", 16'(col), 16'h02A0);
            chk("ap", 16'(ap), 16'(i != 1));
            chk("burst", 16'(b32), 16'(i != 2));
            chk("bank", 16'(bsel), 16'h0002);
         end
      end
      go({1'b1, cad_pkg::REF_CODE}, 6'h05);
      done(1, 0);
      chk("all mask", 16'(mask), 16'h00FF);
      chk("all flag", 16'(ab), 16'h0001);
      go({1'b0, cad_pkg::PRE_CODE}, 6'h03);
      done(1, 0);
      chk("pre mask", 16'(mask), 16'h0008);
      go({1'b1, cad_pkg::MRW1_CODE}, 6'h2D);
      go({1'b1, cad_pkg::MRW2_CODE}, 6'h05);
      done(1, 0);
      chk("operand", 16'(op), 16'h00C5);
      go({1'b0, cad_pkg::MRR1_CODE}, 6'h1A);
      go({1'b0, cad_pkg::CAS2_CODE}, 6'h00);
      done(1, 0);
      chk("index", 16'(idx), 16'h001A);
      go({1'b0, cad_pkg::CAS2_CODE}, 6'h00);
      done(0, 1);
      ctl.cyc(1'b1, 6'h01);
      ctl.cyc(1'b0, 6'h00);
      done(0, 1);
      tally_and_finish();
   end
endmodule
